//--- shared/hsp_pkg.sv
// Overview of operation
// [R1] Indicator asserted at high speed, negated full
// [R2] Indicator polarity set by latched select-hi strap
// [R3] Port power enable: one on, zero off
// [R4] Combined pin: open-drain enable plus overcurrent sense
// [R5] Charge-support strap latched; one enables charging
// [R6] Local supply sampled in configuration after reset
// [R7] Latched supply held unless dynamic switching enabled
// [R8] Switch register resets 0xc1; 0x41 enables dynamic
// [R9] Switch register written by host or config memory
// [R10] Supply detect in use: nonremovable straps ignored
// [R11] Straps latched at power-on and reset release
// [R12] Two select straps choose configuration method
// [R13] Board drives supply detect: zero bus, one local
// [R14] Shared pin output held off until strap latched
package hsp_pkg;
    // ========================================
    // Register map
    localparam logic [15:0] HSP_SWITCH_CTRL_ADDR = 16'h4134;
    localparam logic [7:0] HSP_SWITCH_CTRL_RST = 8'hc1;
    localparam logic [7:0] HSP_SWITCH_CTRL_DYN = 8'h41;
    // ========================================
    // Timing
    localparam int HSP_CLK_MHZ = 125;
    localparam int HSP_CFG_NS = 1000;
    localparam int HSP_CFG_CYCLES = (HSP_CFG_NS * HSP_CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {
        HSP_LATCH = 3'b001,
        HSP_CONFIG = 3'b010,
        HSP_RUN = 3'b100
    } hsp_state_t;
endpackage

//--- hw/hsp_port_power.sv
module hsp_port_power
    import hsp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic outEnable,
    input wire logic combined,
    input wire logic powerOn,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic overcurrentL
);
    logic syncA_reg;
    logic syncB_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncA_reg <= 1'b0;
            syncB_reg <= 1'b0;
        end else begin
            syncA_reg <= pinIn;
            syncB_reg <= syncA_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
            overcurrentL <= 1'b1;
        end else if (!outEnable) begin
            pinOut <= 1'b0; // [R14]
            pinOe <= 1'b0;
            overcurrentL <= 1'b1;
        end else if (combined) begin
            // Open-drain: drive low for off, release for on
            pinOut <= 1'b0; // [R4]
            pinOe <= !powerOn;
            overcurrentL <= powerOn ? syncB_reg : 1'b1;
        end else begin
            pinOut <= powerOn; // [R3]
            pinOe <= 1'b1;
            overcurrentL <= 1'b1;
        end
    end
endmodule

//--- hw/hsp_strap_power.sv
module hsp_strap_power
    import hsp_pkg::*;
#(
    parameter int NUM_PORTS = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic externalChipRstL,
    input wire logic highSpeedConnected,
    input wire logic hsIndPinIn,
    input wire logic configSelectLoIn,
    input wire logic localSupplyDetect,
    input wire logic [1:0] nonremovableStraps,
    input wire logic [NUM_PORTS-1:0] portPinIn,
    input wire logic [NUM_PORTS-1:0] portCombinedCfg,
    input wire logic [NUM_PORTS-1:0] portPowerOn,
    input wire logic [1:0] nonremovableCfg,
    input wire logic regWrite,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic highSpeedIndicator,
    output logic highSpeedIndicatorOe,
    output logic [NUM_PORTS-1:0] portPinOut,
    output logic [NUM_PORTS-1:0] portPinOe,
    output logic [NUM_PORTS-1:0] overcurrentL,
    output logic [NUM_PORTS-1:0] chargeSupport,
    output logic [1:0] configMethod,
    output logic [1:0] nonremovable,
    output logic selfPowered,
    output logic configDone
);
    initial begin
        if (NUM_PORTS < 1 || NUM_PORTS > 8) $error("NUM_PORTS out of range");
    end

    // ========================================
    // Input synchronisers
    logic [3+NUM_PORTS:0] syncA_reg;
    logic [3+NUM_PORTS:0] syncB_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= {externalChipRstL, hsIndPinIn, configSelectLoIn,
                          localSupplyDetect, portPinIn};
            syncB_reg <= syncA_reg;
        end
    end
    logic extRstS;
    logic selHiS;
    logic selLoS;
    logic supplyS;
    logic [NUM_PORTS-1:0] portS;
    assign {extRstS, selHiS, selLoS, supplyS, portS} = syncB_reg;

    // Nonremovable straps are pins too, so they get the same two stages
    logic [1:0] nrSyncA_reg;
    logic [1:0] nrSyncB_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nrSyncA_reg <= 2'h0;
            nrSyncB_reg <= 2'h0;
        end else begin
            nrSyncA_reg <= nonremovableStraps;
            nrSyncB_reg <= nrSyncA_reg;
        end
    end

    logic extRstPrev_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) extRstPrev_reg <= 1'b0;
        else extRstPrev_reg <= extRstS;
    end
    logic extRise;
    assign extRise = extRstS && !extRstPrev_reg;

    // ========================================
    // Sequencer: latch straps, configure, run
    // Drivers drop one edge after leaving run, then two sync stages
    localparam logic [1:0] LATCH_WAIT = 2'h3;
    hsp_state_t state_reg;
    logic [15:0] cfgCnt_reg;
    logic [1:0] latchCnt_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= HSP_LATCH;
            cfgCnt_reg <= '0;
            latchCnt_reg <= 2'h0;
        end else if (extRise) begin
            state_reg <= HSP_LATCH; // [R11]
            latchCnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                HSP_LATCH: begin
                    // Strap pins must show the resistor, not our driver
                    if (latchCnt_reg == LATCH_WAIT) begin
                        state_reg <= HSP_CONFIG;
                        cfgCnt_reg <= '0;
                    end else begin
                        latchCnt_reg <= latchCnt_reg + 2'h1;
                    end
                end
                HSP_CONFIG: begin
                    cfgCnt_reg <= cfgCnt_reg + 16'h0001;
                    if (cfgCnt_reg == 16'(HSP_CFG_CYCLES - 1))
                        state_reg <= HSP_RUN;
                end
                HSP_RUN: state_reg <= HSP_RUN;
                default: begin
                    state_reg <= HSP_LATCH;
                    latchCnt_reg <= 2'h0;
                end
            endcase
        end
    end
    logic latchNow;
    assign latchNow = (state_reg == HSP_LATCH) &&
        (latchCnt_reg == LATCH_WAIT) && !extRise;

    // Supply detect always in use here
    logic supplyUse;
    assign supplyUse = 1'b1;

    // ========================================
    // Strap capture
    logic selHi_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            selHi_reg <= 1'b0;
            configMethod <= 2'h0;
            chargeSupport <= '0;
            nonremovable <= 2'h0;
        end else if (latchNow) begin
            selHi_reg <= selHiS; // [R11]
            configMethod <= {selHiS, selLoS}; // [R12]
            chargeSupport <= portS; // [R5]
            nonremovable <= nrSyncB_reg;
        end else if (state_reg == HSP_RUN && supplyUse) begin
            nonremovable <= nonremovableCfg; // [R10]
        end
    end

    // ========================================
    // Local supply control register
    logic [7:0] switchCtrl_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) switchCtrl_reg <= HSP_SWITCH_CTRL_RST; // [R8]
        else if (regWrite && regAddr == HSP_SWITCH_CTRL_ADDR)
            switchCtrl_reg <= regWdata; // [R9]
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) regRdata <= 8'h00;
        else if (regAddr == HSP_SWITCH_CTRL_ADDR) regRdata <= switchCtrl_reg;
        else regRdata <= 8'h00;
    end
    logic dynamic;
    assign dynamic = (switchCtrl_reg == HSP_SWITCH_CTRL_DYN);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            selfPowered <= 1'b0;
            configDone <= 1'b0;
        end else begin
            configDone <= (state_reg == HSP_RUN);
            if (state_reg == HSP_CONFIG)
                selfPowered <= supplyS; // [R6]
            else if (state_reg == HSP_RUN && dynamic)
                selfPowered <= supplyS; // [R7]
        end
    end

    // ========================================
    // High-speed indicator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            highSpeedIndicator <= 1'b0;
            highSpeedIndicatorOe <= 1'b0;
        end else begin
            highSpeedIndicatorOe <= (state_reg == HSP_RUN); // [R14]
            highSpeedIndicator <= highSpeedConnected ^ selHi_reg; // [R1] [R2]
        end
    end

    // ========================================
    // Port power pins
    for (genvar i = 0; i < NUM_PORTS; i++) begin : gPort
        hsp_port_power uPort (
            .clk(clk),
            .resetn(resetn),
            .outEnable(state_reg == HSP_RUN),
            .combined(portCombinedCfg[i]),
            .powerOn(portPowerOn[i]),
            .pinIn(portPinIn[i]),
            .pinOut(portPinOut[i]),
            .pinOe(portPinOe[i]),
            .overcurrentL(overcurrentL[i])
        );
    end

    // ========================================
    // Checks
    sequence sRunReached;
        state_reg == HSP_RUN;
    endsequence

    AST_HS_POL: assert property (@(posedge clk) disable iff (!resetn) // [R2]
        highSpeedIndicatorOe |-> ##1 (highSpeedIndicator ==
            ($past(highSpeedConnected) ^ selHi_reg)))
        else $error("indicator polarity wrong");
    AST_OE_WAIT: assert property (@(posedge clk) disable iff (!resetn) // [R14]
        (state_reg != HSP_RUN) |=> !highSpeedIndicatorOe)
        else $error("indicator driven before latch");
    AST_HOLD: assert property (@(posedge clk) disable iff (!resetn) // [R7]
        (sRunReached and !dynamic) ##1 sRunReached |-> $stable(selfPowered))
        else $error("supply changed while static");
    AST_DYN: assert property (@(posedge clk) disable iff (!resetn) // [R7]
        (sRunReached and dynamic) ##1 sRunReached |->
            selfPowered == $past(supplyS))
        else $error("dynamic supply not followed");
    AST_CFG_SAMPLE: assert property (@(posedge clk) disable iff (!resetn) // [R6]
        (state_reg == HSP_CONFIG) |=> selfPowered == $past(supplyS))
        else $error("supply not sampled in config");
    AST_LATCH: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        latchNow |=> configMethod == $past({selHiS, selLoS}))
        else $error("straps not latched");
    AST_REG_WR: assert property (@(posedge clk) disable iff (!resetn) // [R9]
        regWrite && regAddr == HSP_SWITCH_CTRL_ADDR |=>
            switchCtrl_reg == $past(regWdata))
        else $error("register write lost");
    AST_REL: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        extRise |=> state_reg == HSP_LATCH)
        else $error("reset release did not relatch");
    AST_PORT_OFF: assert property (@(posedge clk) disable iff (!resetn) // [R14]
        (state_reg != HSP_RUN) |=> portPinOe == '0)
        else $error("port driven before latch");
endmodule

//--- dv/hsp_board_model.sv
// ========================================
// Board side: strap resistors and port switches
module hsp_board_model (
    input wire logic hsIndOut,
    input wire logic hsIndOe,
    input wire logic selHi,
    input wire logic [1:0] pinOut,
    input wire logic [1:0] pinOe,
    input wire logic [1:0] strap,
    input wire logic [1:0] fault,
    output logic hsIndPin,
    output logic [1:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pin falls back to its strap resistor
    assign hsIndPin = hsIndOe ? hsIndOut : selHi;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pinIn[i] = pinOe[i] ? pinOut[i] : strap[i];
            // Switch fault pulls the shared line low
            if (fault[i]) pinIn[i] = 1'b0;
        end
    end
endmodule

//--- dv/tb_hub_strap_and_port_power.sv
module tb_hub_strap_and_port_power;
    import hsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, extRstL = 1'b1, hsConn = 1'b0;
    logic selHi = 1'b0, selLo = 1'b0, localSup = 1'b0, regWrite = 1'b0;
    logic [1:0] nrStraps = 2'h0, nrCfg = 2'h0, strap = 2'h3, fault = 2'h0;
    logic [1:0] combCfg = 2'h0, powerOn = 2'h0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic hsIndPin, hsInd, hsIndOe, selfPow, cfgDone;
    logic [1:0] pinIn, pinOut, pinOe, ovcL, chg, cfgMethod, nonrem;
    int checked = 0, miscompares = 0;
    always #4 clk = ~clk;
    hsp_strap_power #(.NUM_PORTS(2)) i_dut (.clk(clk), .resetn(resetn),
        .externalChipRstL(extRstL), .highSpeedConnected(hsConn),
        .hsIndPinIn(hsIndPin), .configSelectLoIn(selLo),
        .localSupplyDetect(localSup), .nonremovableStraps(nrStraps),
        .portPinIn(pinIn), .portCombinedCfg(combCfg),
        .portPowerOn(powerOn), .nonremovableCfg(nrCfg),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .highSpeedIndicator(hsInd),
        .highSpeedIndicatorOe(hsIndOe), .portPinOut(pinOut),
        .portPinOe(pinOe), .overcurrentL(ovcL), .chargeSupport(chg),
        .configMethod(cfgMethod), .nonremovable(nonrem),
        .selfPowered(selfPow), .configDone(cfgDone));
    hsp_board_model i_board (.hsIndOut(hsInd), .hsIndOe(hsIndOe),
        .selHi(selHi), .pinOut(pinOut), .pinOe(pinOe), .strap(strap),
        .fault(fault), .hsIndPin(hsIndPin), .pinIn(pinIn));
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] exp);
        regAddr = a;
        @(negedge clk);
        chk("regRdata", exp, regRdata);
    endtask
    task automatic flipSupply(int n);
        localSup = ~localSup;
        repeat (n) @(negedge clk);
    endtask
    // Expected {out, oe} of one port pin
    function automatic logic [1:0] pinExp(logic c, logic p);
        return c ? {1'b0, ~p} : {p, 1'b1};
    endfunction
    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hc7520730));
        repeat (8) @(negedge clk);
        chk("ovcL", 8'h03, {6'h0, ovcL});
        chk("pinOe", 8'h00, {5'h0, hsIndOe, pinOe});
        for (int m = 0; m < 4; m++) begin
            {selHi, selLo} = m[1:0];
            {strap, nrStraps, nrCfg} = $urandom;
            localSup = $urandom;
            extRstL = (m == 0);
            repeat (4) @(negedge clk);
            resetn = 1'b1;
            extRstL = 1'b1;
            repeat (140) @(negedge clk);
            chk("cfgDone", 8'h01, {7'h0, cfgDone});
            chk("cfgMethod", m[7:0], {6'h0, cfgMethod});
            chk("chg", {6'h0, strap}, {6'h0, chg});
            chk("selfPow", {7'h0, localSup}, {7'h0, selfPow});
            chk("nonrem", {6'h0, nrCfg}, {6'h0, nonrem});
            rd(HSP_SWITCH_CTRL_ADDR, 8'hc1);
            wr(16'h4135, 8'h41);
            rd(16'h4135, 8'h00);
            flipSupply(8);
            chk("held", {7'h0, ~localSup}, {7'h0, selfPow});
            wr(HSP_SWITCH_CTRL_ADDR, 8'h41);
            rd(HSP_SWITCH_CTRL_ADDR, 8'h41);
            repeat (6) @(negedge clk);
            chk("dyn", {7'h0, localSup}, {7'h0, selfPow});
            flipSupply(8);
            chk("dyn", {7'h0, localSup}, {7'h0, selfPow});
            wr(HSP_SWITCH_CTRL_ADDR, 8'hc1);
            repeat (4) @(negedge clk);
            flipSupply(8);
            chk("held", {7'h0, ~localSup}, {7'h0, selfPow});
            selLo = ~selLo;
            nrStraps = ~nrStraps;
            for (int k = 0; k < 8; k++) begin
                {combCfg, powerOn, hsConn} = $urandom;
                fault = $urandom & combCfg;
                if (k == 0) combCfg = 2'h3;
                repeat (4) @(negedge clk);
                chk("hsInd", {7'h1, hsConn ^ selHi},
                    {6'h0, hsIndOe, hsInd});
                for (int i = 0; i < 2; i++) begin
                    chk("pin", {6'h0, pinExp(combCfg[i], powerOn[i])},
                        {6'h0, pinOut[i], pinOe[i]});
                    chk("ovcL", {7'h0, ~(combCfg[i] & powerOn[i]) |
                        (strap[i] & ~fault[i])}, {7'h0, ovcL[i]});
                end
            end
            chk("cfgMethod", m[7:0], {6'h0, cfgMethod});
            fault = 2'h0;
            combCfg = 2'h0;
        end
        print_verdict();
    end
endmodule
